// >>> src/pulse_timer_pkg.sv
/*
 * Package for the pulse-output timer: register offsets, field positions,
 * reset values, mode and source encodings, and the bus request carrier.
 * Assumes a single 250 MHz system clock domain.
 */
package pulse_timer_pkg;

    // Register word offsets (byte addresses, one aligned word each).
    localparam logic [3:0] OFF_PRESCALER = 4'h0;
    localparam logic [3:0] OFF_PERIOD = 4'h4;
    localparam logic [3:0] OFF_PIN_IO = 4'h8;
    localparam logic [3:0] OFF_MODE = 4'hc;
    localparam logic [3:0] OFF_RUN = 4'h0 + 4'h0 + 4'h0 + 4'h0;
    localparam logic [4:0] OFF_RUN_BYTE = 5'h10;

    // Pin I/O control fields.
    localparam int PIO_POLARITY = 0;
    localparam int PIO_OUT_CTRL = 1;
    localparam int PIO_INV_ENA = 2;

    // Mode register fields.
    localparam int MODE_LSB = 0;
    localparam int SRC_LSB = 4;
    localparam int SRC_GATE_OFF = 7;
    localparam logic [2:0] MODE_PULSE = 3'h1;
    localparam logic [2:0] SRC_DIV8 = 3'h1;

    // Run control fields.
    localparam int RUN_BIT = 0;
    localparam int FLAG_BIT = 1;

    // Reset values.
    localparam logic [7:0] RST_PRESCALER = 8'hff;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_PIN_IO = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_RUN = 8'h00;

    // Count source divide ratio and derived last divider count.
    localparam int SRC_DIV = 8;
    localparam logic [2:0] SRC_DIV_LAST = 3'(SRC_DIV - 1);

    // One Avalon-MM request as seen by the slave.
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_s;

endpackage

// >>> src/clock_div_by_eight.sv
/*
 * Count source generator: a one-cycle tick every eighth system clock.
 * Assumes a synchronous active-high reset and a free-running clock.
 */
`timescale 1ns/1ns
module clock_div_by_eight
    import pulse_timer_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic enable, // Divider runs only while high.
    output logic tick // One-cycle count source pulse.
);
    import pulse_timer_pkg::*;

    typedef struct packed {
        logic [2:0] div;
        logic tick;
    } div_state_s;

    div_state_s state_r;
    div_state_s state_nxt;

    // Restarting from zero on enable keeps the first period a full eight.
    always_comb begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (!enable) begin
            state_nxt.div = 3'h0;
        end else if (state_r.div == SRC_DIV_LAST) begin
            state_nxt.div = 3'h0;
            state_nxt.tick = 1'b1;
        end else begin
            state_nxt.div = state_r.div + 3'h1;
        end
    end

    // Registered state.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tick = state_r.tick;

    a_tick_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick |=> !tick [*7])
        else $error("Count source tick came sooner than eight clocks.");

endmodule

// >>> src/timer_pulse_output_mode.sv
/*
 * Pulse-output timer: eight-bit prescaler cascaded into an eight-bit
 * period counter, toggling a square-wave pin on each period underflow.
 * Registers sit behind an Avalon-MM slave with waitrequest; the slave
 * answers every access one cycle after it is presented.
 * Assumes one system clock and a synchronous active-high reset.
 */
// Function
// - An eight-bit writable prescaler counts down on the count source and takes any load value.
// - An eight-bit period counter decrements once per prescaler underflow.
// - With polarity 0 the primary output starts high when counting starts.
// - With output control 0 the primary pin drives the pulse waveform.
// - With inverted output enable 1 the second pin drives the inverse of the primary output.
// - Mode field value 001 selects pulse output mode.
// - Source field value 001 selects the system clock divided by eight.
// - Source gate off 0 supplies the count source, 1 cuts it off.
// - Writing 1 to the run bit starts counting and writing 0 stops it.
// - The read-only counting flag follows the run bit one clock later.
`timescale 1ns/1ns
module timer_pulse_output_mode
    import pulse_timer_pkg::*;
(
    input wire logic clk_sys, // System clock, 250 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [4:0] avsAddress, // Byte address of the register.
    input wire logic avsRead, // Read request.
    input wire logic avsWrite, // Write request.
    input wire logic [31:0] avsWritedata, // Write data.
    input wire logic [3:0] avsByteenable, // Byte enables, lane 0 used.
    output logic [31:0] avsReaddata, // Read data, valid with answer.
    output logic avsWaitrequest, // High until the access is taken.
    output logic primaryPulseOut, // Primary pulse pin level.
    output logic primaryPulseOe_n, // Primary pin enable, low drives.
    output logic invertedPulseOut, // Inverted pulse pin level.
    output logic invertedPulseOe_n, // Inverted pin enable, low drives.
    output logic underflowEvent // One-cycle pulse per period underflow.
);
    import pulse_timer_pkg::*;

    typedef struct packed {
        logic [7:0] prescalerReload;
        logic [7:0] periodReload;
        logic [7:0] prescalerCount;
        logic [7:0] periodCount;
        logic [7:0] pinIoControl;
        logic [7:0] modeRegister;
        logic runBit;
        logic countingFlag;
        logic pulseLevel;
        logic ack;
        logic [31:0] readdata;
        logic primaryOut;
        logic primaryOe_n;
        logic invertedOut;
        logic invertedOe_n;
        logic event_;
    } timer_state_s;

    timer_state_s state_r;
    timer_state_s state_nxt;
    bus_req_s req;
    logic srcTick;
    logic srcEnable;
    logic pulseMode;
    logic wrHit;
    logic [7:0] wrByte;

    // Reads back a register image; unmapped addresses read as zero.
    function automatic logic [7:0] readMux(input timer_state_s s,
                                           input logic [4:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            {1'b0, OFF_PRESCALER}: v = s.prescalerCount;
            {1'b0, OFF_PERIOD}: v = s.periodCount;
            {1'b0, OFF_PIN_IO}: v = s.pinIoControl;
            {1'b0, OFF_MODE}: v = s.modeRegister;
            OFF_RUN_BYTE: begin
                v[RUN_BIT] = s.runBit;
                v[FLAG_BIT] = s.countingFlag;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign req = '{address: avsAddress, read: avsRead, write: avsWrite,
                   writedata: avsWritedata};
    // Only the low byte lane carries register bits.
    assign wrHit = req.write && !state_r.ack && avsByteenable[0];
    assign wrByte = req.writedata[7:0];
    assign pulseMode = state_r.modeRegister[MODE_LSB +: 3] == MODE_PULSE;
    // The source runs only when selected, not cut off, and counting.
    assign srcEnable = state_r.countingFlag && pulseMode
        && state_r.modeRegister[SRC_LSB +: 3] == SRC_DIV8
        && !state_r.modeRegister[SRC_GATE_OFF];

    clock_div_by_eight u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(srcEnable),
        .tick(srcTick)
    );

    // Next-state logic for bus slave, registers, counters and pins.
    always_comb begin
        state_nxt = state_r;
        state_nxt.event_ = 1'b0;
        // Every access is answered one cycle after it appears.
        state_nxt.ack = (req.read || req.write) && !state_r.ack;
        if (req.read && !state_r.ack) begin
            state_nxt.readdata = {24'h0, readMux(state_r, req.address)};
        end
        // The flag lags the run bit by one clock so software can poll it.
        state_nxt.countingFlag = state_r.runBit;
        if (!state_r.countingFlag && state_r.runBit) begin
            state_nxt.pulseLevel = !state_r.pinIoControl[PIO_POLARITY];
        end
        // Counting: the prescaler underflow steps the period counter.
        if (srcTick) begin
            if (state_r.prescalerCount == 8'h00) begin
                state_nxt.prescalerCount = state_r.prescalerReload;
                if (state_r.periodCount == 8'h00) begin
                    state_nxt.periodCount = state_r.periodReload;
                    state_nxt.pulseLevel = !state_r.pulseLevel;
                    state_nxt.event_ = 1'b1;
                end else begin
                    state_nxt.periodCount = state_r.periodCount - 8'h01;
                end
            end else begin
                state_nxt.prescalerCount = state_r.prescalerCount - 8'h01;
            end
        end
        // Register writes; a counter write loads both reload and count.
        if (wrHit) begin
            case (req.address)
                {1'b0, OFF_PRESCALER}: begin
                    state_nxt.prescalerReload = wrByte;
                    state_nxt.prescalerCount = wrByte;
                end
                {1'b0, OFF_PERIOD}: begin
                    state_nxt.periodReload = wrByte;
                    state_nxt.periodCount = wrByte;
                end
                {1'b0, OFF_PIN_IO}: state_nxt.pinIoControl = wrByte;
                {1'b0, OFF_MODE}: state_nxt.modeRegister = wrByte;
                OFF_RUN_BYTE: state_nxt.runBit = wrByte[RUN_BIT];
                default: state_nxt.runBit = state_r.runBit;
            endcase
        end
        // Pins: outputs enabled only in pulse mode, with enables low-true.
        state_nxt.primaryOut = state_nxt.pulseLevel;
        state_nxt.primaryOe_n = !(pulseMode
            && !state_r.pinIoControl[PIO_OUT_CTRL]);
        state_nxt.invertedOut = !state_nxt.pulseLevel;
        state_nxt.invertedOe_n = !(pulseMode
            && state_r.pinIoControl[PIO_INV_ENA]);
    end

    // Single register for all state.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.prescalerReload <= RST_PRESCALER;
            state_r.prescalerCount <= RST_PRESCALER;
            state_r.periodReload <= RST_PERIOD;
            state_r.periodCount <= RST_PERIOD;
            state_r.pinIoControl <= RST_PIN_IO;
            state_r.modeRegister <= RST_MODE;
            state_r.runBit <= RST_RUN[RUN_BIT];
            state_r.primaryOe_n <= 1'b1;
            state_r.invertedOe_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Waitrequest is the inverse of the registered acknowledge.
    assign avsWaitrequest = !state_r.ack;
    assign avsReaddata = state_r.readdata;
    assign primaryPulseOut = state_r.primaryOut;
    assign primaryPulseOe_n = state_r.primaryOe_n;
    assign invertedPulseOut = state_r.invertedOut;
    assign invertedPulseOe_n = state_r.invertedOe_n;
    assign underflowEvent = state_r.event_;

    sequence s_run_write;
        avsWrite && !state_r.ack && avsByteenable[0]
            && avsAddress == OFF_RUN_BYTE && avsWritedata[RUN_BIT];
    endsequence

    a_flag_lags_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_run_write |=> state_r.runBit ##1 state_r.countingFlag)
        else $error("Counting flag did not follow the run bit.");

    a_run_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
        avsWrite && !state_r.ack && avsByteenable[0]
        && avsAddress == OFF_RUN_BYTE && !avsWritedata[RUN_BIT]
        |=> !state_r.runBit)
        else $error("Run bit did not clear on a stop write.");

    a_start_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(state_r.countingFlag) && !state_r.pinIoControl[PIO_POLARITY]
        && !$past(srcTick) |-> state_r.pulseLevel)
        else $error("Primary output did not start high.");

    a_toggle_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
        underflowEvent |-> primaryPulseOut != $past(primaryPulseOut))
        else $error("Underflow event without an output toggle.");

    a_gate_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r.modeRegister[SRC_GATE_OFF] |=> !srcTick)
        else $error("Count source ran while cut off.");

    a_prescale_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        srcTick && state_r.prescalerCount != 8'h00 && !wrHit
        |=> state_r.prescalerCount == $past(state_r.prescalerCount) - 8'h01)
        else $error("Prescaler did not step down on a tick.");

    a_period_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        srcTick && state_r.prescalerCount != 8'h00 && !wrHit
        |=> $stable(state_r.periodCount))
        else $error("Period counter moved without prescaler underflow.");

    a_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
        srcTick && state_r.prescalerCount == 8'h00 && !wrHit
        |=> state_r.prescalerCount == $past(state_r.prescalerReload))
        else $error("Prescaler did not reload on underflow.");

    a_inverse_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !invertedPulseOe_n |-> invertedPulseOut == !primaryPulseOut)
        else $error("Inverted pin is not the inverse of the primary.");

    a_primary_oe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pulseMode && !state_r.pinIoControl[PIO_OUT_CTRL]
        |=> !primaryPulseOe_n)
        else $error("Primary pin not driven in pulse mode.");

    a_mode_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !pulseMode |=> !srcTick)
        else $error("Counting outside pulse output mode.");

endmodule

// >>> verification/pulse_pin_load.sv
/*
 * Load on the two pulse pins: resolves each wire from its driver enable,
 * counts primary toggles and the clocks between the last two of them.
 * Assumes the timer's system clock and no pull resistor on either pin.
 */
`timescale 1ns/1ns
module pulse_pin_load (
    input wire logic clk_sys, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic primaryOut, // Primary pin level from the timer.
    input wire logic primaryOe_n, // Primary pin enable, low drives.
    input wire logic invertedOut, // Inverted pin level from the timer.
    input wire logic invertedOe_n, // Inverted pin enable, low drives.
    output logic primaryWire, // Resolved primary wire.
    output logic invertedWire, // Resolved inverted wire.
    output int toggles, // Primary wire toggles while driven.
    output int halfPeriod // Clocks between the last two toggles.
);
    logic primaryLast_r = 1'b0;
    logic invertedLast_r = 1'b0;
    int gap_r = 0;

    // An undriven wire flips every cycle, so a stale level never passes.
    assign primaryWire = primaryOe_n ? ~primaryLast_r : primaryOut;
    assign invertedWire = invertedOe_n ? ~invertedLast_r : invertedOut;

    // Toggles count only while driven; the gap restarts at each toggle.
    always_ff @(posedge clk_sys) begin
        primaryLast_r <= primaryWire;
        invertedLast_r <= invertedWire;
        if (sys_rst) begin
            toggles <= 0;
            halfPeriod <= 0;
            gap_r <= 0;
        end else if (!primaryOe_n && primaryWire != primaryLast_r) begin
            toggles <= toggles + 1;
            halfPeriod <= gap_r;
            gap_r <= 1;
        end else begin
            gap_r <= gap_r + 1;
        end
    end
endmodule

// >>> verification/tb_top.sv
/*
 * Self-checking bench for the pulse-output timer: register access over
 * Avalon-MM, pulse timing, polarity, pin enables and refused settings.
 * Assumes the design answers each access and a pin load model beside it.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin numErrors++; \
    $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    import pulse_timer_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest, primaryPulseOut, primaryPulseOe_n;
    logic invertedPulseOut, invertedPulseOe_n, underflowEvent;
    logic primaryWire, invertedWire;
    int toggles, halfPeriod;
    int numErrors = 0;
    int checked = 0;
    logic [15:0] lfsr = 16'hdae7;
    localparam logic [4:0] aPre = {1'b0, OFF_PRESCALER};
    localparam logic [4:0] aPer = {1'b0, OFF_PERIOD};
    localparam logic [4:0] aPio = {1'b0, OFF_PIN_IO};
    localparam logic [4:0] aMode = {1'b0, OFF_MODE};
    localparam logic [4:0] aRun = OFF_RUN_BYTE;

    timer_pulse_output_mode i_timer_pulse_output_mode (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .primaryPulseOut(primaryPulseOut),
        .primaryPulseOe_n(primaryPulseOe_n),
        .invertedPulseOut(invertedPulseOut),
        .invertedPulseOe_n(invertedPulseOe_n),
        .underflowEvent(underflowEvent));
    pulse_pin_load i_pulse_pin_load (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .primaryOut(primaryPulseOut), .primaryOe_n(primaryPulseOe_n),
        .invertedOut(invertedPulseOut), .invertedOe_n(invertedPulseOe_n),
        .primaryWire(primaryWire), .invertedWire(invertedWire),
        .toggles(toggles), .halfPeriod(halfPeriod));

    // Clock of 4 ns period.
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // Sixteen-bit LFSR; the fixed start makes every run repeat.
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    // Clocks between underflows for a prescaler and period setting.
    function automatic int expPeriod(input logic [7:0] p, input logic [7:0] q);
        return SRC_DIV * (int'(p) + 1) * (int'(q) + 1);
    endfunction

    task automatic end_sim();
        if (numErrors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One access; the request is held until waitrequest is sampled low.
    task automatic busXfer(input logic wr, input logic [4:0] a,
        input logic [7:0] d, input logic [3:0] be, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        avsAddress <= a;
        avsWritedata <= {24'h0, d};
        avsByteenable <= be;
        avsWrite <= wr;
        avsRead <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 100);
        rd = avsReaddata;
        if (n == 100) numErrors++;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic regWr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] rd;
        busXfer(1'b1, a, d, 4'h1, rd);
    endtask

    task automatic regChk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] rd;
        busXfer(1'b0, a, 8'h00, 4'h1, rd);
        `CHK(rd, {24'h0, e})
    endtask

    // Polls the counting flag; it lags the run bit, so software waits.
    task automatic waitFlag(input logic v);
        logic [31:0] rd;
        int n;
        n = 0;
        do begin
            busXfer(1'b0, aRun, 8'h00, 4'h1, rd);
            n++;
        end while (rd[FLAG_BIT] !== v && n < 20);
        `CHK(rd[FLAG_BIT], v)
    endtask

    // Full pulse run: configure while stopped, start, time one period.
    task automatic runPulse(input logic [7:0] p, input logic [7:0] q,
        input logic pol);
        int n;
        int t0;
        regWr(aPio, {5'h00, 1'b1, 1'b0, pol});
        regWr(aPre, p);
        regWr(aPer, q);
        regWr(aMode, {1'b0, SRC_DIV8, 1'b0, MODE_PULSE});
        regWr(aRun, 8'h01);
        waitFlag(1'b1);
        `CHK(primaryPulseOut, ~pol)
        `CHK(primaryPulseOe_n, 1'b0)
        `CHK(invertedPulseOe_n, 1'b0)
        `CHK(invertedWire, ~primaryWire)
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (underflowEvent !== 1'b1 && n < 3000);
        t0 = toggles;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (underflowEvent !== 1'b1 && n < 3000);
        `CHK(n, expPeriod(p, q))
        `CHK(toggles - t0, 1)
        // The load model latches the gap on the edge that sees the toggle.
        @(posedge clk_sys);
        `CHK(halfPeriod, expPeriod(p, q))
        `CHK(invertedPulseOut, ~primaryPulseOut)
        regWr(aRun, 8'h00);
        waitFlag(1'b0);
    endtask

    // Hang guard, reckoned well above the longest expected sequence.
    initial begin
        repeat (60000) @(posedge clk_sys);
        numErrors++;
        end_sim();
    end

    initial begin
        logic [4:0] addrs[6] = '{aPre, aPer, aPio, aMode, aRun, 5'h14};
        logic [7:0] rsts[6] = '{RST_PRESCALER, RST_PERIOD, RST_PIN_IO,
            RST_MODE, RST_RUN, 8'h00};
        logic [7:0] refused[3] = '{8'h91, 8'h21, 8'h12};
        logic [7:0] v;
        logic [31:0] rd;
        int e;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        `CHK(primaryPulseOe_n, 1'b1)
        // Reset values, an unmapped read among them.
        for (int i = 0; i < 6; i++) begin
            regChk(addrs[i], rsts[i]);
        end
        // Counter registers take any value, corners first.
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
            regWr(aPre, v);
            regChk(aPre, v);
            regWr(aPer, ~v);
            regChk(aPer, ~v);
        end
        // A write without lane 0 enabled leaves the register alone.
        busXfer(1'b1, aPer, 8'h5a, 4'h0, rd);
        regChk(aPer, ~v);
        // The counting flag cannot be written.
        regWr(aRun, 8'h02);
        regChk(aRun, 8'h00);
        runPulse(8'h00, 8'h00, 1'b0);
        runPulse(8'h03, 8'h01, 1'b1);
        repeat (3) begin
            v = rnd();
            runPulse({6'h00, v[1:0]}, {6'h00, v[3:2]}, v[4]);
        end
        // Shortest period, so any counting would show within the window.
        regWr(aPre, 8'h00);
        regWr(aPer, 8'h00);
        // Gate off, another source and another mode must not count.
        for (int i = 0; i < 3; i++) begin
            regWr(aMode, refused[i]);
            regWr(aRun, 8'h01);
            e = 0;
            repeat (100) begin
                @(posedge clk_sys);
                if (underflowEvent !== 1'b0) e++;
            end
            `CHK(e, 0)
            regWr(aRun, 8'h00);
            waitFlag(1'b0);
        end
        `CHK(primaryPulseOe_n, 1'b1)
        end_sim();
    end
endmodule
